// *** verilog/sdm_params.svh ***
// constants for the serial duplex mode control block
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH

// =====================================================
// register offsets (byte addresses)
`define SDM_OFF_CTRL 12'h000
`define SDM_OFF_FSM 12'h004
`define SDM_OFF_STAT 12'h008

// =====================================================
// field positions
`define SDM_CTRL_ECHO_SUP0 0
`define SDM_CTRL_FDX0 1
`define SDM_CTRL_ECHO_SUP1 8
`define SDM_CTRL_FDX1 9
`define SDM_STAT_CH_STRIDE 8

// =====================================================
// reset values
`define SDM_CTRL_RESET 32'h0000_0000
`define SDM_FSM_RESET 3'h0

// =====================================================
// timing: led blink half period and flash time, in ms
`define SDM_CLK_HZ 125000000
`define SDM_BLINK_MS 200
`define SDM_FLASH_MS 200
`define SDM_SINGLE_PERIOD_MS 1200
`define SDM_BLINK_CYC ((`SDM_CLK_HZ / 1000) * `SDM_BLINK_MS)
`define SDM_FLASH_CYC ((`SDM_CLK_HZ / 1000) * `SDM_FLASH_MS)
`define SDM_SINGLE_CYC ((`SDM_CLK_HZ / 1000) * `SDM_SINGLE_PERIOD_MS)

`endif

// *** verilog/sdm_pkg.sv ***
// types for the serial duplex mode control block
package sdm_pkg;

	// fieldbus state machine state as written by software
	typedef enum logic [2:0] {
		SDM_ST_INIT = 3'h0,
		SDM_ST_PRE_OPERATIONAL = 3'h1,
		SDM_ST_FIRMWARE_BOOT = 3'h2,
		SDM_ST_SAFE_OPERATIONAL = 3'h3,
		SDM_ST_OPERATIONAL = 3'h4
	} sdm_fsm_type;

	// per-channel line direction state
	typedef enum logic [1:0] {
		SDM_CH_IDLE = 2'h0,
		SDM_CH_TX = 2'h1,
		SDM_CH_RX = 2'h2,
		SDM_CH_DRAIN = 2'h3
	} sdm_ch_type;

endpackage

// *** verilog/sdm_channel.sv ***
// one serial channel: duplex / echo gating and activity leds
`timescale 1ns/100ps
module sdm_channel
	import sdm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic echo_sup_cfg,
	input wire logic fdx_cfg,
	input wire logic tx_busy,
	input wire logic rx_line,
	input wire logic rx_busy,
	output logic rx_enable,
	output logic rx_data,
	output logic tx_drive_en,
	output logic tx_activity_led,
	output logic rx_activity_led,
	output logic echo_sup_act,
	output logic fdx_act,
	output sdm_pkg::sdm_ch_type ch_state
);
	import sdm_pkg::*;

	logic rx_line_s1_q;
	logic rx_line_s2_q;
	logic rx_busy_s1_q;
	logic rx_busy_s2_q;
	logic echo_sup_q;
	logic fdx_q;
	sdm_ch_type state_q;
	sdm_ch_type state_d;
	logic tx_activity_q;
	logic rx_activity_q;
	logic rx_data_q;

	// =====================================================
	// line inputs
	// two stage synchroniser; the first stage feeds the second only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_line_s1_q <= 1'b1;
			rx_line_s2_q <= 1'b1;
			rx_busy_s1_q <= 1'b0;
			rx_busy_s2_q <= 1'b0;
		end else begin
			rx_line_s1_q <= rx_line;
			rx_line_s2_q <= rx_line_s1_q;
			rx_busy_s1_q <= rx_busy;
			rx_busy_s2_q <= rx_busy_s1_q;
		end
	end

	// =====================================================
	// mode flags
	// flags latch only while idle so a character is never cut
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			echo_sup_q <= 1'b0;
			fdx_q <= 1'b0;
		end else if (state_q == SDM_CH_IDLE && !tx_busy) begin
			echo_sup_q <= echo_sup_cfg;
			fdx_q <= fdx_cfg;
		end
	end

	// =====================================================
	// direction state
	always_comb begin
		state_d = state_q;
		case (state_q)
			SDM_CH_IDLE: begin
				if (tx_busy)
					state_d = SDM_CH_TX;
				else if (rx_busy_s2_q)
					state_d = SDM_CH_RX;
			end
			SDM_CH_TX: begin
				if (!tx_busy)
					state_d = SDM_CH_DRAIN;
			end
			SDM_CH_RX: begin
				if (!rx_busy_s2_q)
					state_d = SDM_CH_IDLE;
			end
			SDM_CH_DRAIN: begin
				// one cycle after the last bit before the receiver reopens
				state_d = SDM_CH_IDLE;
			end
			default: begin
				state_d = SDM_CH_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_q <= SDM_CH_IDLE;
		else
			state_q <= state_d;
	end

	// =====================================================
	// receive gating per mode
	always_comb begin
		case ({echo_sup_q, fdx_q})
			2'b01: rx_enable = 1'b1;
			2'b11: rx_enable = (state_q == SDM_CH_IDLE) || (state_q == SDM_CH_RX);
			2'b10: rx_enable = (state_q != SDM_CH_TX) && (state_q != SDM_CH_DRAIN);
			default: rx_enable = (state_q != SDM_CH_DRAIN);
		endcase
	end

	// half duplex: line driver on only while sending, never with a new receive
	assign tx_drive_en = fdx_q ? 1'b1 : (state_q == SDM_CH_TX);

	// received bit held high (idle) when gated off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_data_q <= 1'b1;
		else
			rx_data_q <= rx_enable ? rx_line_s2_q : 1'b1;
	end

	// =====================================================
	// activity leds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_activity_q <= 1'b0;
			rx_activity_q <= 1'b0;
		end else begin
			tx_activity_q <= tx_busy;
			rx_activity_q <= rx_busy_s2_q && rx_enable;
		end
	end

	assign rx_data = rx_data_q;
	assign tx_activity_led = tx_activity_q;
	assign rx_activity_led = rx_activity_q;
	assign echo_sup_act = echo_sup_q;
	assign fdx_act = fdx_q;
	assign ch_state = state_q;

	// =====================================================
	// checks
	AST_HDX_NO_RX_WHILE_TX: assert property (@(posedge pclk) disable iff (!presetn)
		(!fdx_q && state_q == SDM_CH_TX) |-> !rx_enable || !echo_sup_q)
		else $error("receive open while sending in suppressed half duplex");
	// plain four-wire full duplex keeps its receiver open through the drain cycle
	AST_RX_AFTER_TX: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == SDM_CH_DRAIN && !(fdx_q && !echo_sup_q)) |-> !rx_enable ##1 (state_q == SDM_CH_IDLE))
		else $error("receive reopened before transmission completed");
	AST_FDX_ALWAYS_RX: assert property (@(posedge pclk) disable iff (!presetn)
		(fdx_q && !echo_sup_q) |-> rx_enable && tx_drive_en)
		else $error("full duplex mode not both ways");
	AST_RS422_GATED: assert property (@(posedge pclk) disable iff (!presetn)
		(fdx_q && echo_sup_q && $rose(tx_busy) && state_q == SDM_CH_IDLE) |=> !rx_enable)
		else $error("receiver open during send in gated four-wire mode");
	AST_ECHO_DROP: assert property (@(posedge pclk) disable iff (!presetn)
		(echo_sup_q && !fdx_q && state_q == SDM_CH_TX) |=> rx_data_q)
		else $error("own echo passed in suppressed mode");
	AST_OWN_ECHO: assert property (@(posedge pclk) disable iff (!presetn)
		(!echo_sup_q && !fdx_q && state_q == SDM_CH_TX) |-> rx_enable)
		else $error("own echo lost in plain half duplex");
	AST_TX_LED: assert property (@(posedge pclk) disable iff (!presetn)
		tx_busy |=> tx_activity_led)
		else $error("transmit led dark while sending");
	AST_FLAGS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q != SDM_CH_IDLE) |=> $stable(fdx_q) && $stable(echo_sup_q))
		else $error("mode changed mid character");
endmodule

// *** verilog/sdm_top.sv ***
// serial duplex mode control: apb registers, run led and channels
//
// Operation
// - on the shared two-wire line a channel never drives and accepts new data at once; with echo suppression off the receiver stays open while sending.
// - in two-wire mode with echo suppression, reception stays off until the own transmission has completed.
// - the echo suppression flag can keep a channel from receiving its own characters.
// - echo off and full duplex off: two-wire, own and foreign data both received.
// - echo off and full duplex on: four-wire, send and receive at the same time.
// - echo on and full duplex off: two-wire, only foreign data is passed.
// - echo on and full duplex on: four-wire, receiver opened only after the last sent data.
// - the run led is dark in init and in firmware boot.
// - the run led blinks in pre-operational.
// - the run led gives single flashes in safe-operational.
// - the run led is steadily lit in operational.
// - each channel lights its transmit led while sending.
// - each channel lights its receive led while receiving.
// - two independent channels each with own flags, paths and leds.
//
// Our own choices: the register offsets and the APB interface to the registers.
`include "sdm_params.svh"
`timescale 1ns/100ps
module sdm_top #(
	parameter int NUM_CH = 2,
	parameter int BLINK_CYC = `SDM_BLINK_CYC,
	parameter int FLASH_CYC = `SDM_FLASH_CYC,
	parameter int SINGLE_CYC = `SDM_SINGLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CH-1:0] tx_busy,
	input wire logic [NUM_CH-1:0] rx_line,
	input wire logic [NUM_CH-1:0] rx_busy,
	output logic [NUM_CH-1:0] rx_enable,
	output logic [NUM_CH-1:0] rx_data,
	output logic [NUM_CH-1:0] tx_drive_en,
	output logic [NUM_CH-1:0] tx_activity_led,
	output logic [NUM_CH-1:0] rx_activity_led,
	output logic run_led
);
	import sdm_pkg::*;

	logic [31:0] ctrl_q;
	sdm_fsm_type fsm_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [NUM_CH-1:0] echo_act;
	logic [NUM_CH-1:0] fdx_act;
	sdm_ch_type ch_state [NUM_CH];
	logic [31:0] blink_cnt_q;
	logic blink_q;
	logic [31:0] single_cnt_q;
	logic run_led_q;
	logic [31:0] stat_w;
	logic acc;

	// address decode used by the read path for the error response
	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == `SDM_OFF_CTRL) || (a == `SDM_OFF_FSM) || (a == `SDM_OFF_STAT);
	endfunction

	// =====================================================
	// apb slave: zero wait states
	assign acc = psel && penable;
	assign pready = 1'b1;

	// control and state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `SDM_CTRL_RESET;
			fsm_q <= sdm_fsm_type'(`SDM_FSM_RESET);
		end else if (acc && pwrite) begin
			if (paddr == `SDM_OFF_CTRL)
				ctrl_q <= pwdata;
			if (paddr == `SDM_OFF_FSM) begin
				// unknown codes fall back to init so the led stays dark
				case (pwdata[2:0])
					3'h1: fsm_q <= SDM_ST_PRE_OPERATIONAL;
					3'h2: fsm_q <= SDM_ST_FIRMWARE_BOOT;
					3'h3: fsm_q <= SDM_ST_SAFE_OPERATIONAL;
					3'h4: fsm_q <= SDM_ST_OPERATIONAL;
					default: fsm_q <= SDM_ST_INIT;
				endcase
			end
		end
	end

	// status word: per channel live flags, direction state and leds
	always_comb begin
		stat_w = 32'h0000_0000;
		for (int i = 0; i < NUM_CH; i++) begin
			stat_w[i*`SDM_STAT_CH_STRIDE +: 8] = {1'b0, rx_activity_led[i], tx_activity_led[i],
				rx_enable[i], ch_state[i], fdx_act[i], echo_act[i]};
		end
	end

	// read data registered in the setup phase, ready for the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_q <= !addr_known(paddr);
			case (paddr)
				`SDM_OFF_CTRL: prdata_q <= ctrl_q & 32'h0000_0303;
				`SDM_OFF_FSM: prdata_q <= {29'h0000_0000, fsm_q};
				`SDM_OFF_STAT: prdata_q <= stat_w;
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q && acc;

	// =====================================================
	// run led timing: blink toggle and single flash period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_q <= 32'h0000_0000;
			blink_q <= 1'b0;
		end else if (blink_cnt_q >= 32'(BLINK_CYC - 1)) begin
			blink_cnt_q <= 32'h0000_0000;
			blink_q <= !blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			single_cnt_q <= 32'h0000_0000;
		else if (single_cnt_q >= 32'(SINGLE_CYC - 1))
			single_cnt_q <= 32'h0000_0000;
		else
			single_cnt_q <= single_cnt_q + 32'h0000_0001;
	end

	// run led pattern from the fieldbus state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_led_q <= 1'b0;
		end else begin
			case (fsm_q)
				SDM_ST_PRE_OPERATIONAL: run_led_q <= blink_q;
				SDM_ST_SAFE_OPERATIONAL: run_led_q <= single_cnt_q < 32'(FLASH_CYC);
				SDM_ST_OPERATIONAL: run_led_q <= 1'b1;
				default: run_led_q <= 1'b0;
			endcase
		end
	end

	assign run_led = run_led_q;

	AST_RUN_DARK: assert property (@(posedge pclk) disable iff (!presetn)
		(fsm_q == SDM_ST_INIT || fsm_q == SDM_ST_FIRMWARE_BOOT) ##1 $stable(fsm_q) |-> !run_led)
		else $error("run led lit in init or boot");
	AST_RUN_ON: assert property (@(posedge pclk) disable iff (!presetn)
		(fsm_q == SDM_ST_OPERATIONAL) ##1 (fsm_q == SDM_ST_OPERATIONAL) |-> run_led)
		else $error("run led not steady in operational");

	// =====================================================
	// channels, each with its own pair of flags
	generate
		for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
			sdm_channel u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.echo_sup_cfg(ctrl_q[`SDM_CTRL_ECHO_SUP0 + g*`SDM_STAT_CH_STRIDE]),
				.fdx_cfg(ctrl_q[`SDM_CTRL_FDX0 + g*`SDM_STAT_CH_STRIDE]),
				.tx_busy(tx_busy[g]),
				.rx_line(rx_line[g]),
				.rx_busy(rx_busy[g]),
				.rx_enable(rx_enable[g]),
				.rx_data(rx_data[g]),
				.tx_drive_en(tx_drive_en[g]),
				.tx_activity_led(tx_activity_led[g]),
				.rx_activity_led(rx_activity_led[g]),
				.echo_sup_act(echo_act[g]),
				.fdx_act(fdx_act[g]),
				.ch_state(ch_state[g])
			);
		end
	endgenerate
endmodule

// *** sim/sdm_station_model.sv ***
// remote serial station model driving the receive side of both channels
`timescale 1ns/100ps
module sdm_station_model (
	input wire logic pclk,
	output logic [1:0] rx_line,
	output logic [1:0] rx_busy
);
	// ==========================================
	// line state
	// idle pair rests high, as a biased receive pair does
	initial begin
		rx_line = 2'h3;
		rx_busy = 2'h0;
	end

	// ==========================================
	// traffic
	// one foreign frame: line low with framing busy, then the pair is released to idle
	task automatic frame(input int ch, input int len);
		@(posedge pclk);
		rx_line[ch] <= 1'b0;
		rx_busy[ch] <= 1'b1;
		repeat (len) @(posedge pclk);
		rx_line[ch] <= 1'b1;
		rx_busy[ch] <= 1'b0;
	endtask

	// own echo on a shared pair shows as a level only, the receiver framer stays quiet
	task automatic echo(input int ch, input logic lvl);
		rx_line[ch] <= lvl;
	endtask
endmodule

// *** sim/test_serial_duplex_mode_control.sv ***
// self-checking bench for the serial duplex mode control block
`timescale 1ns/100ps
module test_serial_duplex_mode_control;
	import sdm_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, run_led;
	logic [1:0] tx_busy = 2'h0, rx_line, rx_busy, rx_enable, rx_data, tx_drive_en, tx_activity_led, rx_activity_led;
	logic [31:0] lfsr_q = 32'h1fef7ac8;
	int failures = 0, checked = 0, ones;

	// ==========================================
	// clock, design and far side
	always #4 pclk = ~pclk;
	// short led counts keep the run brief; expectations below use the same figures
	sdm_top #(.NUM_CH(2), .BLINK_CYC(4), .FLASH_CYC(2), .SINGLE_CYC(12)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_busy(tx_busy), .rx_line(rx_line), .rx_busy(rx_busy),
		.rx_enable(rx_enable), .rx_data(rx_data), .tx_drive_en(tx_drive_en), .tx_activity_led(tx_activity_led),
		.rx_activity_led(rx_activity_led), .run_led(run_led));
	sdm_station_model station (.pclk(pclk), .rx_line(rx_line), .rx_busy(rx_busy));

	// ==========================================
	// reference model: mode is {full duplex, echo suppress}, phase 0 idle, 1 sending, 3 draining
	function automatic logic exp_rx_en(input logic [1:0] m, input int ph);
		return (ph == 0) || (m[0] == 1'b0 && (ph == 1 || m[1] == 1'b1));
	endfunction
	// four-wire keeps its driver on; a shared pair is driven only while sending
	function automatic logic exp_drv(input logic [1:0] m, input int ph);
		return m[1] || (ph == 1);
	endfunction
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// apb transfer: request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one transmission on channel 0 while channel 1 sits idle in its own mode
	task automatic run_mode(input logic [1:0] m, input logic [1:0] m1);
		apb(1'b1, 12'h000, {22'h0, m1, 6'h0, m}, rd, err);
		repeat (3) @(posedge pclk);
		tx_busy[0] <= 1'b1;
		station.echo(0, 1'b0);
		repeat (5) @(posedge pclk);
		#1;
		chk(rx_enable, {1'b1, exp_rx_en(m, 1)});
		chk(tx_drive_en, {exp_drv(m1, 0), exp_drv(m, 1)});
		chk(tx_activity_led, 2'h1);
		chk(rx_data, {1'b1, ~exp_rx_en(m, 1)});
		// status byte per channel: leds, receive enable, direction state, live flags
		apb(1'b0, 12'h008, 32'h0, rd, err);
		chk(rd, {16'h0, 4'h1, 2'b00, m1, 3'b001, exp_rx_en(m, 1), 2'b01, m});
		// a mode write in mid-character must not reach the channel yet
		apb(1'b1, 12'h000, {22'h0, m1, 6'h0, ~m}, rd, err);
		#1;
		chk(rx_enable[0], exp_rx_en(m, 1));
		@(posedge pclk);
		tx_busy[0] <= 1'b0;
		station.echo(0, 1'b1);
		@(posedge pclk);
		#1;
		chk({rx_enable[0], tx_drive_en[0]}, {exp_rx_en(m, 3), exp_drv(m, 3)});
		@(posedge pclk);
		#1;
		chk(rx_enable[0], 1'b1);
		chk(tx_activity_led, 2'h0);
		$display("test mode %0d done", m);
	endtask
	// run led: ones counted over three whole blink periods and two flash periods
	task automatic led_case(input sdm_fsm_type s, input int exp_ones);
		apb(1'b1, 12'h004, {29'h0, s}, rd, err);
		repeat (30) @(posedge pclk);
		ones = 0;
		repeat (24) begin
			@(posedge pclk);
			#1;
			ones += (run_led === 1'b1);
		end
		chk(ones, exp_ones);
		$display("test run led state %0d done", s);
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, rd, err);
		chk(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0, rd, err);
		chk(rd, 32'h0);
		lfsr_q = lfsr_next(lfsr_q);
		apb(1'b1, 12'h000, lfsr_q, rd, err);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		chk(rd, lfsr_q & 32'h0000_0303);
		apb(1'b0, 12'h00c, 32'h0, rd, err);
		chk({err, rd}, {1'b1, 32'h0});
		$display("test registers done");
		for (int m = 0; m < 4; m++) begin
			lfsr_q = lfsr_next(lfsr_q);
			run_mode(m[1:0], lfsr_q[1:0]);
		end
		apb(1'b1, 12'h000, 32'h0000_0002, rd, err);
		fork
			station.frame(1, 10);
			begin
				repeat (7) @(posedge pclk);
				#1;
				chk(rx_activity_led, 2'h2);
				chk(rx_data, 2'h1);
			end
		join
		$display("test receive done");
		led_case(SDM_ST_INIT, 0);
		led_case(SDM_ST_FIRMWARE_BOOT, 0);
		led_case(SDM_ST_PRE_OPERATIONAL, 12);
		led_case(SDM_ST_SAFE_OPERATIONAL, 4);
		led_case(SDM_ST_OPERATIONAL, 24);
		// an unknown state code falls back to init, so the led goes dark again
		led_case(sdm_fsm_type'(3'h7), 0);
		conclude();
	end

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		conclude();
	end
endmodule
